// >>> logic/reset_ctrl_pkg.sv
// Package: constants and carriers for the reset controller and mode-strap latch
package reset_ctrl_pkg;

    // ********************************************************************
    // Timing and address constants
    // ********************************************************************
    localparam int unsigned STRETCH_CYCLES     = 512;     // Minimum reset hold
    localparam logic [9:0]  STRETCH_LAST       = 10'h1FF;
    localparam logic [3:0]  FIRST_BUS_CYCLES   = 4'hA;    // Release to first bus cycle
    localparam logic [23:0] VECTOR_TABLE_BASE  = 24'h000000;
    localparam logic [23:0] VECTOR_TABLE_BYTES = 24'h000200;
    localparam logic [23:0] RESET_VECTOR_FIRST = 24'h000000;
    localparam logic [23:0] RESET_VECTOR_LAST  = 24'h000006;
    localparam logic [1:0]  VECTOR_STEP        = 2'h2;

    // Strap line positions on the data bus
    localparam int unsigned STRAP_BOOT_WIDTH = 0;
    localparam int unsigned STRAP_ARBITRATE  = 1;
    localparam int unsigned STRAP_FUNC_CODE  = 2;
    localparam int unsigned STRAP_ADDR_LO    = 3;
    localparam int unsigned STRAP_PORT_E     = 8;
    localparam int unsigned STRAP_PORT_F     = 9;
    localparam int unsigned STRAP_TEST       = 11;

    // ********************************************************************
    // Carriers
    // ********************************************************************
    typedef struct packed {
        logic external_pin;    // Synchronous sources
        logic loss_of_clock;
        logic test;
        logic power_up;        // Asynchronous sources
        logic watchdog;
        logic halt_monitor;
    } reset_cause_s;

    typedef struct packed {
        logic       boot_port_16;      // 1 = 16-bit boot port
        logic       bus_arb_pins;      // Request, grant, acknowledge
        logic       function_codes;    // Function code outputs
        logic [4:0] addr_lines;        // Bit k: chip select 6+k is address 19+k
        logic       discrete_port_e;
        logic       discrete_port_f;
        logic       test_mode;
        logic       synth_clock;       // 1 = synthesizer, 0 = external clock
        logic       background_mode;   // Breakpoints enter debug mode
    } strap_config_s;

    localparam strap_config_s STRAP_DEFAULT = '{boot_port_16: 1'b1, synth_clock: 1'b1,
                                                default: '0};

endpackage

// >>> logic/reset_control_mode_select.sv
// Reset controller: cause capture, reset line drive, strap and vector sequencing
`timescale 1ns/1ns
module reset_control_mode_select
    import reset_ctrl_pkg::*;
(
    input  wire logic          clock_i,
    input  wire logic          reset_i,
    input  wire logic          reset_pin_n_i,       // Sampled pin level
    input  wire logic          loss_of_clock_i,
    input  wire logic          test_reset_i,
    input  wire logic          power_up_i,
    input  wire logic          watchdog_i,
    input  wire logic          halt_monitor_i,
    input  wire logic          bus_cycle_end_i,     // Current bus cycle terminates
    input  wire logic          bus_idle_i,          // No bus cycle in flight
    input  wire logic [15:0]   data_strap_i,
    input  wire logic          clock_mode_strap_i,
    input  wire logic [1:0]    breakpoint_input_n_i,
    input  wire logic          vector_ack_i,        // Vector word fetched
    output logic               master_reset_line_o,
    output logic               clock_module_reset_o,
    output logic               pin_reset_drive_o,
    output logic               bus_monitor_force_o,
    output logic               abort_processing_o,
    output logic               boot_chip_select_o,
    output logic               vector_fetch_o,
    output logic [23:0]        vector_addr_o,
    output logic               breakpoint_exception_o,
    output logic               background_entry_o,
    output strap_config_s      strap_config_o,
    output reset_cause_s       reset_cause_o
);

    typedef enum logic [2:0] {
        ST_RUN, ST_WAIT_CYCLE, ST_ASSERT, ST_RELEASE, ST_VECTORS
    } reset_state_e;

    // ********************************************************************
    // State declarations
    // ********************************************************************
    reset_state_e  state_q, state_d;
    reset_cause_s  cause_q, cause_d, req_now;
    strap_config_s strap_q, strap_d;
    logic [9:0]    count_q, count_d;
    logic [23:0]   vaddr_q, vaddr_d;
    logic          mst_q, mst_d, clk_q, clk_d, ext_q, ext_d;
    logic          mon_q, mon_d, abort_q, abort_d, boot_q, boot_d, vf_q, vf_d;
    logic          bkx_q, bkx_d, bdm_q, bdm_d;
    logic          sync_req, async_req;
    logic          bk_now;

    // Requests seen this edge; the pin counts only when clocked
    always_comb begin
        req_now.external_pin  = ~reset_pin_n_i;
        req_now.loss_of_clock = loss_of_clock_i;
        req_now.test          = test_reset_i;
        req_now.power_up      = power_up_i;
        req_now.watchdog      = watchdog_i;
        req_now.halt_monitor  = halt_monitor_i;
    end

    // Classification by timing
    assign sync_req  = req_now.external_pin | req_now.loss_of_clock | req_now.test;
    assign async_req = req_now.power_up | req_now.watchdog | req_now.halt_monitor;
    assign bk_now    = ~breakpoint_input_n_i[0] | ~breakpoint_input_n_i[1];

    // ********************************************************************
    // Sequencer next state
    // ********************************************************************
    // Reset outranks all else: any request preempts vector fetch or run
    always_comb begin
        state_d = state_q;
        cause_d = cause_q;
        count_d = count_q;
        vaddr_d = vaddr_q;
        mon_d   = mon_q;
        abort_d = 1'b0;
        boot_d  = boot_q;
        vf_d    = vf_q;
        unique case (state_q)
            ST_RUN, ST_VECTORS: begin
                if (async_req) begin
                    // Catastrophic: act on this very edge
                    state_d = ST_ASSERT;
                    cause_d = req_now;
                    count_d = '0;
                    abort_d = 1'b1;
                    vf_d    = 1'b0;
                    boot_d  = 1'b0;
                end else if (sync_req) begin
                    // Wait for the bus cycle to end; monitor unsticks it
                    state_d = ST_WAIT_CYCLE;
                    cause_d = req_now;
                    mon_d   = 1'b1;
                end else if (state_q == ST_VECTORS && vector_ack_i) begin
                    // Four initialisation words, 0000 to 0006
                    if (vaddr_q == RESET_VECTOR_LAST) begin
                        state_d = ST_RUN;
                        vf_d    = 1'b0;
                    end else begin
                        vaddr_d = vaddr_q + {22'h000000, VECTOR_STEP};
                    end
                end
            end
            ST_WAIT_CYCLE: begin
                cause_d = cause_q | req_now;
                if (async_req) begin
                    state_d = ST_ASSERT;
                    count_d = '0;
                    abort_d = 1'b1;
                    mon_d   = 1'b0;
                    vf_d    = 1'b0;
                    boot_d  = 1'b0;
                end else if (bus_cycle_end_i || bus_idle_i) begin
                    // Writes in flight finish before reset lands
                    state_d = ST_ASSERT;
                    count_d = '0;
                    abort_d = 1'b1;
                    mon_d   = 1'b0;
                    vf_d    = 1'b0;
                    boot_d  = 1'b0;
                end
            end
            ST_ASSERT: begin
                // Hold lines at least 512 cycles and while any source persists
                cause_d = cause_q | req_now;
                if (count_q != STRETCH_LAST) begin
                    count_d = count_q + 10'h001;
                end else if (!(sync_req || async_req)) begin
                    state_d = ST_RELEASE;
                end
            end
            ST_RELEASE: begin
                // Last capture was the release edge; values frozen from here
                boot_d  = 1'b1;
                vf_d    = 1'b1;
                vaddr_d = RESET_VECTOR_FIRST;
                state_d = ST_VECTORS;
            end
            default: state_d = ST_RUN;
        endcase
    end

    // ********************************************************************
    // State registers
    // ********************************************************************
    // Block reset behaves as power-up: sequencer starts in the hold
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            state_q <= ST_ASSERT;
            cause_q <= '{power_up: 1'b1, default: '0};
            count_q <= '0;
            vaddr_q <= RESET_VECTOR_FIRST;
            mon_q   <= 1'b0;
            abort_q <= 1'b0;
            boot_q  <= 1'b0;
            vf_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            cause_q <= cause_d;
            count_q <= count_d;
            vaddr_q <= vaddr_d;
            mon_q   <= mon_d;
            abort_q <= abort_d;
            boot_q  <= boot_d;
            vf_q    <= vf_d;
        end
    end

    // ********************************************************************
    // Reset line drive
    // ********************************************************************
    // Lines rise one edge after the hold starts and drop on the release step
    always_comb begin
        mst_d = mst_q;
        clk_d = clk_q;
        ext_d = ext_q;
        if (state_q == ST_ASSERT) begin
            // Every source pulls master and pin; a test alone spares the clock module
            mst_d = 1'b1;
            ext_d = 1'b1;
            clk_d = |{cause_q.external_pin, cause_q.loss_of_clock, cause_q.power_up,
                      cause_q.watchdog, cause_q.halt_monitor};
        end else if (state_q == ST_RELEASE) begin
            mst_d = 1'b0;
            clk_d = 1'b0;
            ext_d = 1'b0;
        end
    end

    // Block reset holds all three lines from the first edge, as at power-up
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            mst_q <= 1'b1;
            clk_q <= 1'b1;
            ext_q <= 1'b1;
        end else begin
            mst_q <= mst_d;
            clk_q <= clk_d;
            ext_q <= ext_d;
        end
    end

    // ********************************************************************
    // Mode strap capture
    // ********************************************************************
    // Straps follow the pins through the hold; the release edge keeps the last copy
    always_comb begin
        strap_d = strap_q;
        if (state_q == ST_ASSERT) begin
            // Pull-ups read high and keep the default choice
            strap_d.boot_port_16    = data_strap_i[STRAP_BOOT_WIDTH];
            strap_d.bus_arb_pins    = ~data_strap_i[STRAP_ARBITRATE];
            strap_d.function_codes  = ~data_strap_i[STRAP_FUNC_CODE];
            // A low strap k drags down every lower chip select to six
            for (int k = 0; k < 5; k++) begin
                strap_d.addr_lines[k] = 1'b0;
                for (int j = k; j < 5; j++) begin
                    if (!data_strap_i[STRAP_ADDR_LO + j]) begin
                        strap_d.addr_lines[k] = 1'b1;
                    end
                end
            end
            strap_d.discrete_port_e = ~data_strap_i[STRAP_PORT_E];
            strap_d.discrete_port_f = ~data_strap_i[STRAP_PORT_F];
            strap_d.test_mode       = ~data_strap_i[STRAP_TEST];
            strap_d.synth_clock     = clock_mode_strap_i;
            strap_d.background_mode = bk_now;
        end
    end

    // Nothing outside the hold reaches the copy, so it stands until next reset
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            strap_q <= STRAP_DEFAULT;
        end else begin
            strap_q <= strap_d;
        end
    end

    // ********************************************************************
    // Breakpoint routing
    // ********************************************************************
    // A reset request in the same cycle outranks any breakpoint
    always_comb begin
        bkx_d = 1'b0;
        bdm_d = 1'b0;
        if (state_q == ST_RUN && bk_now && !(sync_req || async_req)) begin
            bdm_d = strap_q.background_mode;
            bkx_d = ~strap_q.background_mode;
        end
    end

    // Pulses repeat while the input stays low; callers see one per cycle
    always_ff @(posedge clock_i) begin
        if (reset_i) begin
            bkx_q <= 1'b0;
            bdm_q <= 1'b0;
        end else begin
            bkx_q <= bkx_d;
            bdm_q <= bdm_d;
        end
    end

    // Outputs straight from flops
    assign master_reset_line_o    = mst_q;
    assign clock_module_reset_o   = clk_q;
    assign pin_reset_drive_o      = ext_q;
    assign bus_monitor_force_o    = mon_q;
    assign abort_processing_o     = abort_q;
    assign boot_chip_select_o     = boot_q;
    assign vector_fetch_o         = vf_q;
    assign vector_addr_o          = vaddr_q;
    assign breakpoint_exception_o = bkx_q;
    assign background_entry_o     = bdm_q;
    assign strap_config_o         = strap_q;
    assign reset_cause_o          = cause_q;

endmodule

// >>> bench/reset_control_mode_select_assertions.sv
// Checker: port-level timing relations of the reset controller
`timescale 1ns/1ns
module reset_control_checker
    import reset_ctrl_pkg::*;
(
    input wire logic          clock_i, reset_i, reset_pin_n_i,
    input wire logic          loss_of_clock_i, test_reset_i, power_up_i,
    input wire logic          watchdog_i, halt_monitor_i, bus_cycle_end_i,
    input wire logic          bus_idle_i, vector_ack_i,
    input wire logic [1:0]    breakpoint_input_n_i,
    input wire logic          master_reset_line_o, pin_reset_drive_o,
    input wire logic          bus_monitor_force_o, abort_processing_o, boot_chip_select_o,
    input wire logic          vector_fetch_o, breakpoint_exception_o, background_entry_o,
    input wire logic [23:0]   vector_addr_o,
    input wire strap_config_s strap_config_o
);
    // ****************************************
    // Source grouping and quiet running state
    // ****************************************
    wire logic async_src = power_up_i | watchdog_i | halt_monitor_i;
    wire logic sync_src  = !reset_pin_n_i | loss_of_clock_i | test_reset_i;
    wire logic quiet     = !(master_reset_line_o | vector_fetch_o | bus_monitor_force_o
                             | async_src | sync_src);

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    // Hand-off and vector steps as named sequences
    sequence boot_start_s;
        boot_chip_select_o && vector_fetch_o && vector_addr_o == RESET_VECTOR_FIRST;
    endsequence
    sequence ack_mid_s;
        vector_fetch_o && vector_ack_i && vector_addr_o != RESET_VECTOR_LAST;
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    lines_paired_a: assert property (master_reset_line_o |-> pin_reset_drive_o)
        else $error("Master reset without pin drive");
    async_take_a: assert property (async_src && !master_reset_line_o
        |-> ##[1:3] master_reset_line_o) else $error("Async source not taken in time");
    sync_hold_a: assert property (sync_src && !async_src && !master_reset_line_o
        && !abort_processing_o && !bus_cycle_end_i && !bus_idle_i
        && !$past(bus_cycle_end_i) && !$past(bus_idle_i) |=> !master_reset_line_o)
        else $error("Sync reset applied inside a bus cycle");
    monitor_on_a: assert property (sync_src && !master_reset_line_o
        |-> ##[0:2] (bus_monitor_force_o || master_reset_line_o))
        else $error("Bus monitor not forced for sync reset");
    abort_take_a: assert property (abort_processing_o
        |=> master_reset_line_o && !abort_processing_o) else $error("Abort pulse wrong");
    boot_start_a: assert property ($fell(master_reset_line_o) |-> boot_start_s)
        else $error("Release hand-off wrong");
    vector_step_a: assert property (ack_mid_s |=> vector_fetch_o
        && vector_addr_o == $past(vector_addr_o) + 24'h000002) else $error("Vector step wrong");
    vector_end_a: assert property (vector_fetch_o && vector_ack_i
        && vector_addr_o == RESET_VECTOR_LAST |=> !vector_fetch_o) else $error("Fetch not ended");
    strap_frozen_a: assert property (!master_reset_line_o && !$fell(master_reset_line_o)
        |-> $stable(strap_config_o)) else $error("Straps changed outside reset");
    breakpoint_input_route_a: assert property (quiet && breakpoint_input_n_i != 2'b11
        |=> (strap_config_o.background_mode ? background_entry_o : breakpoint_exception_o))
        else $error("Breakpoint routed wrongly");
    breakpoint_input_yield_a: assert property (async_src || sync_src
        |=> !breakpoint_exception_o && !background_entry_o)
        else $error("Breakpoint issued beside a reset request");
endmodule

bind reset_control_mode_select reset_control_checker i_checker (.*);

// >>> bench/strap_source.sv
// Partner model: data-bus and clock-mode strap conditioning with weak pull-ups
`timescale 1ns/1ns
module strap_source (
    input  wire logic        clock_i,
    input  wire logic        pin_reset_i,   // Device reset pin drive
    input  wire logic [15:0] pattern_i,     // Zero bits are held low
    input  wire logic        mode_i,
    output logic      [15:0] data_o,
    output logic             mode_o
);
    logic drive_q;
    // Let go one cycle after the pin releases, far ahead of the first bus cycle
    always_ff @(posedge clock_i) drive_q <= pin_reset_i;
    // Released lines float to the pull-up level, never keep the last value
    assign data_o = drive_q ? pattern_i : 16'hFFFF;
    assign mode_o = drive_q ? mode_i : 1'b1;
endmodule

// >>> bench/reset_control_mode_select_test.sv
// Self-checking bench: reset sources, strap capture, vector walk, breakpoints
`timescale 1ns/1ns
module reset_control_mode_select_test;
    import reset_ctrl_pkg::*;
    // ****************************************
    // Signals and expectation queues
    // ****************************************
    logic          clock_i = 1'b0, reset_i = 1'b1, bus_cycle_end_i = 1'b0, bus_idle_i = 1'b0;
    logic          reset_pin_n_i, loss_of_clock_i, test_reset_i, power_up_i, watchdog_i;
    logic          halt_monitor_i, clock_mode_strap_i, mode_pat = 1'b1, vector_ack_i = 1'b0;
    logic [1:0]    breakpoint_input_n_i = 2'b11;
    logic [15:0]   data_strap_i, pattern;
    logic          master_reset_line_o, clock_module_reset_o, pin_reset_drive_o;
    logic          bus_monitor_force_o, abort_processing_o, boot_chip_select_o;
    logic          vector_fetch_o, breakpoint_exception_o, background_entry_o;
    logic [23:0]   vector_addr_o, prev_addr = 24'h000000;
    strap_config_s strap_config_o, exp_strap[$];
    reset_cause_s  reset_cause_o;
    logic [5:0]    src = 6'h00;     // Same bit order as the cause struct
    logic [23:0]   exp_vec[$];
    logic [1:0]    exp_bp[$];
    logic          prev_master = 1'b1, prev_fetch = 1'b0;
    int            n_errors = 0, compares = 0, seed = 32'hB2F1;

    assign reset_pin_n_i = ~src[5];
    assign {loss_of_clock_i, test_reset_i, power_up_i, watchdog_i, halt_monitor_i} = src[4:0];

    reset_control_mode_select i_dut (.*);
    strap_source i_straps (
        .clock_i     (clock_i),
        .pin_reset_i (pin_reset_drive_o),
        .pattern_i   (pattern),
        .mode_i      (mode_pat),
        .data_o      (data_strap_i),
        .mode_o      (clock_mode_strap_i)
    );

    always #4 clock_i = ~clock_i;

    // ****************************************
    // Checking helpers
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            n_errors++;
            $display("BAD at %0t seen %h want %h", $time, seen, want);
        end
    endtask

    task automatic stop_test;
        if (n_errors == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // Straps read low mean the alternate choice, so most fields invert the line
    function automatic strap_config_s expect_straps(input logic [15:0] d, input logic m,
                                                    input logic [1:0] b);
        strap_config_s e;
        e = '{boot_port_16: d[0], bus_arb_pins: ~d[1], function_codes: ~d[2],
              discrete_port_e: ~d[8], discrete_port_f: ~d[9], test_mode: ~d[11],
              synth_clock: m, background_mode: ~&b, addr_lines: 5'h00};
        for (int k = 0; k < 5; k++) begin
            for (int j = k; j < 5; j++) e.addr_lines[k] |= ~d[3 + j];
        end
        return e;
    endfunction

    // Bounded wait on the master line; running out ends the run
    task automatic wait_master(input logic want);
        int n = 0;
        while (master_reset_line_o !== want && n < 700) begin
            @(negedge clock_i);
            n++;
        end
        if (n == 700) begin
            n_errors++;
            stop_test();
        end
    endtask

    task automatic expect_boot(input logic [1:0] bk);
        exp_strap.push_back(expect_straps(pattern, mode_pat, bk));
        for (int a = 0; a < 8; a += 2) exp_vec.push_back(24'(a));
    endtask

    // Release, four vector acknowledges, then one short breakpoint
    task automatic walk(input logic [1:0] bk);
        wait_master(1'b0);
        breakpoint_input_n_i = 2'b11;
        check(boot_chip_select_o, 1'b1);
        check({clock_module_reset_o, pin_reset_drive_o}, 2'b00);
        repeat (4) begin
            @(negedge clock_i);
            vector_ack_i = 1'b1;
            @(negedge clock_i);
            vector_ack_i = 1'b0;
        end
        @(negedge clock_i);
        check(vector_fetch_o, 1'b0);
        breakpoint_input_n_i = 2'b10;
        exp_bp.push_back({&bk, ~&bk});
        @(negedge clock_i);
        breakpoint_input_n_i = 2'b11;
        repeat (3) @(negedge clock_i);
    endtask

    // Output watcher: each appearing result takes the oldest note
    always @(negedge clock_i) begin
        if (prev_master && !master_reset_line_o && exp_strap.size() > 0)
            check(strap_config_o, exp_strap.pop_front());
        if (vector_fetch_o && (!prev_fetch || vector_addr_o != prev_addr) && exp_vec.size() > 0)
            check(vector_addr_o, exp_vec.pop_front());
        if ((breakpoint_exception_o || background_entry_o) && exp_bp.size() > 0)
            check({breakpoint_exception_o, background_entry_o}, exp_bp.pop_front());
        prev_master = master_reset_line_o;
        prev_fetch = vector_fetch_o;
        prev_addr = vector_addr_o;
    end

    // ****************************************
    // Main sequence: power-up, then every source in turn
    // ****************************************
    initial begin
        logic [1:0] bk;
        pattern = 16'($random(seed));
        breakpoint_input_n_i = 2'b01;
        expect_boot(2'b01);
        repeat (3) @(negedge clock_i);
        reset_i = 1'b0;
        walk(2'b01);
        for (int i = 0; i < 6; i++) begin
            pattern = 16'($random(seed));
            mode_pat = 1'($random(seed));
            bk = (i == 2) ? 2'b11 : 2'($random(seed));
            @(negedge clock_i);
            breakpoint_input_n_i = bk;
            src = 6'h01 << i;
            @(negedge clock_i);
            check({breakpoint_exception_o, background_entry_o}, 2'b00);
            repeat (3) @(negedge clock_i);
            if (i >= 3) begin
                check({master_reset_line_o, bus_monitor_force_o}, 2'b01);
                // Clock loss finds the bus idle; the others wait for a cycle end
                if (i == 4) bus_idle_i = 1'b1;
                else bus_cycle_end_i = 1'b1;
                @(negedge clock_i);
                bus_cycle_end_i = 1'b0;
                bus_idle_i = 1'b0;
            end else begin
                check(master_reset_line_o, 1'b1);
            end
            wait_master(1'b1);
            check({clock_module_reset_o, pin_reset_drive_o}, {i != 3, 1'b1});
            check(6'(reset_cause_o) & src, src);
            expect_boot(bk);
            repeat (20) @(negedge clock_i);
            src = 6'h00;
            walk(bk);
        end
        check(exp_strap.size() + exp_vec.size() + exp_bp.size(), 0);
        stop_test();
    end
endmodule
